//--- rtl/bvl_pkg.sv
`default_nettype none
package bvl_pkg;
    localparam int unsigned CODE_W = 6;
    localparam int unsigned RANGE_W = 2;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] BUCK_TWO_VOLTAGE_LIMIT_OFS     = 8'h09;
    localparam logic [ADDR_W-1:0] BUCK_THREE_OPERATING_VOLTAGE_OFS = 8'h0a;
    localparam logic [ADDR_W-1:0] BUCK_THREE_SCALING_VOLTAGE_OFS = 8'h0b;
    localparam logic [ADDR_W-1:0] BUCK_THREE_VOLTAGE_LIMIT_OFS   = 8'h0c;
    localparam logic [ADDR_W-1:0] BUCK_FOUR_OPERATING_VOLTAGE_OFS = 8'h0d;

    // field positions
    localparam int unsigned RANGE_LSB = 6;
    localparam int unsigned RANGE_MSB = 7;
    localparam int unsigned CODE_LSB = 0;
    localparam int unsigned CODE_MSB = 5;
    localparam int unsigned ENABLE_BIT = 7;
    localparam int unsigned SOURCE_BIT = 6;
    localparam int unsigned RESERVED_BIT = 7;

    // ceiling values that leave the limit fields unlocked
    localparam logic [CODE_W-1:0] CEIL_OPEN_HIGH = 6'h3f;
    localparam logic [CODE_W-1:0] CEIL_OPEN_LOW = 6'h00;

    localparam logic RESERVED_BIT_VALUE = 1'b0;
    localparam logic SOURCE_RESET = 1'b0;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

    // output range selector encodings
    typedef enum logic [RANGE_W-1:0] {
        BVL_RANGE_FINE_LOW  = 2'b00,
        BVL_RANGE_FINE_HIGH = 2'b01,
        BVL_RANGE_MEDIUM    = 2'b10,
        BVL_RANGE_COARSE    = 2'b11
    } bvl_range_t;

    typedef struct packed {
        bvl_range_t        range;
        logic [CODE_W-1:0] ceiling;
    } bvl_limit_t;

    typedef struct packed {
        logic              code_source_select;
        logic [CODE_W-1:0] code;
    } bvl_operating_t;

    typedef struct packed {
        logic              enable;
        logic              light_load;
        logic [CODE_W-1:0] code;
    } bvl_scaling_t;
endpackage : bvl_pkg
`default_nettype wire

//--- rtl/bvl_clamp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bvl_clamp_if;
    import bvl_pkg::*;
    logic [CODE_W-1:0] requested;
    logic [CODE_W-1:0] ceiling;
    logic [CODE_W-1:0] granted;
    modport requester (output requested, output ceiling, input granted);
    modport limiter (input requested, input ceiling, output granted);
endinterface : bvl_clamp_if
`default_nettype wire

//--- rtl/bvl_clamp.sv
`timescale 1ns/1ps
`default_nettype none
module bvl_clamp (
    // code path
    bvl_clamp_if.limiter clamp
);
    import bvl_pkg::*;

    // codes above the ceiling are replaced by the ceiling itself
    always_comb begin
        if (clamp.requested > clamp.ceiling) begin
            clamp.granted = clamp.ceiling;
        end else begin
            clamp.granted = clamp.requested;
        end
    end
endmodule // bvl_clamp
`default_nettype wire

//--- rtl/bvl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module bvl_regs (
    // clock and power-on reset
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    // programmed configuration defaults and reload strobe
    input  wire logic                          cfg_reload,
    input  wire bvl_pkg::bvl_limit_t           cfg_buck_two_limit,
    input  wire bvl_pkg::bvl_limit_t           cfg_buck_three_limit,
    input  wire logic                          cfg_buck_three_enable,
    input  wire logic [bvl_pkg::CODE_W-1:0]    cfg_buck_three_op_code,
    input  wire logic [bvl_pkg::CODE_W-1:0]    cfg_buck_three_avs_code,
    input  wire logic [bvl_pkg::CODE_W-1:0]    cfg_buck_four_op_code,
    // register access from the serial control interface
    input  wire logic                          reg_write,
    input  wire logic [bvl_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [bvl_pkg::DATA_W-1:0]    reg_wdata,
    output logic      [bvl_pkg::DATA_W-1:0]    reg_rdata,
    // neighbouring converter state
    input  wire logic [bvl_pkg::CODE_W-1:0]    buck_four_ceiling,
    input  wire logic                          buck_three_forced_off,
    // converter controls
    output bvl_pkg::bvl_range_t                buck_two_range,
    output logic      [bvl_pkg::CODE_W-1:0]    buck_two_ceiling,
    output logic                               buck_two_locked,
    output bvl_pkg::bvl_range_t                buck_three_range,
    output logic      [bvl_pkg::CODE_W-1:0]    buck_three_code,
    output logic                               buck_three_enable,
    output logic                               buck_three_light_load,
    output logic                               buck_three_locked,
    output logic      [bvl_pkg::CODE_W-1:0]    buck_four_op_code,
    output logic                               buck_four_code_source_select
);
    import bvl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        bvl_limit_t     b2_limit;
        bvl_operating_t b3_op;
        bvl_scaling_t   b3_avs;
        bvl_limit_t     b3_limit;
        bvl_operating_t b4_op;
        logic [DATA_W-1:0] rdata;
        logic           b3_enable;
        logic [CODE_W-1:0] b3_code;
    } bvl_state_t;

    bvl_state_t state;
    bvl_state_t next_state;

    ////////////////////////////////////////////////////////////////////////
    // ceiling clamps for the three voltage code fields

    bvl_clamp_if b3_op_clamp ();
    bvl_clamp_if b3_avs_clamp ();
    bvl_clamp_if b4_op_clamp ();

    bvl_clamp u_b3_op_clamp (
        .clamp (b3_op_clamp)
    );

    bvl_clamp u_b3_avs_clamp (
        .clamp (b3_avs_clamp)
    );

    bvl_clamp u_b4_op_clamp (
        .clamp (b4_op_clamp)
    );

    // only codes written over the bus are clamped: lowering a ceiling later
    // leaves codes already held alone, and defaults are taken as they come;
    // a ceiling of zero clamps every written code to zero
    logic [CODE_W-1:0] wr_code;
    assign wr_code = reg_wdata[CODE_MSB:CODE_LSB];

    assign b3_op_clamp.requested = wr_code;
    assign b3_op_clamp.ceiling = state.b3_limit.ceiling;
    assign b3_avs_clamp.requested = wr_code;
    assign b3_avs_clamp.ceiling = state.b3_limit.ceiling;
    assign b4_op_clamp.requested = wr_code;
    assign b4_op_clamp.ceiling = buck_four_ceiling;

    ////////////////////////////////////////////////////////////////////////
    // lock detection: lock follows the held ceiling, so it arises equally
    // from a write or from defaults and only a reload or power-on reset can lift it

    function automatic logic ceiling_locks(input logic [CODE_W-1:0] c);
        ceiling_locks = (c != CEIL_OPEN_HIGH) && (c != CEIL_OPEN_LOW);
    endfunction

    logic b2_lock;
    logic b3_lock;
    assign b2_lock = ceiling_locks(state.b2_limit.ceiling);
    assign b3_lock = ceiling_locks(state.b3_limit.ceiling);

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic [DATA_W-1:0] read_value;

    always_comb begin
        next_state = state;
        if (reg_write) begin
            unique case (reg_addr)
                BUCK_TWO_VOLTAGE_LIMIT_OFS: begin
                    if (!b2_lock) begin
                        next_state.b2_limit = bvl_limit_t'(reg_wdata);
                    end
                end
                BUCK_THREE_OPERATING_VOLTAGE_OFS: begin
                    next_state.b3_op.code_source_select =
                        reg_wdata[SOURCE_BIT];
                    next_state.b3_op.code = b3_op_clamp.granted;
                end
                BUCK_THREE_SCALING_VOLTAGE_OFS: begin
                    next_state.b3_avs.enable = reg_wdata[ENABLE_BIT];
                    next_state.b3_avs.light_load = reg_wdata[SOURCE_BIT];
                    next_state.b3_avs.code = b3_avs_clamp.granted;
                end
                BUCK_THREE_VOLTAGE_LIMIT_OFS: begin
                    if (!b3_lock) begin
                        next_state.b3_limit = bvl_limit_t'(reg_wdata);
                    end
                end
                BUCK_FOUR_OPERATING_VOLTAGE_OFS: begin
                    next_state.b4_op.code_source_select =
                        reg_wdata[SOURCE_BIT];
                    next_state.b4_op.code = b4_op_clamp.granted;
                end
                default: begin
                end
            endcase
        end

        // read data, reserved bit forced to its fixed value; taken from the
        // held state, so a read at the same edge as a write shows the old byte
        unique case (reg_addr)
            BUCK_TWO_VOLTAGE_LIMIT_OFS:
                read_value = DATA_W'(state.b2_limit);
            BUCK_THREE_OPERATING_VOLTAGE_OFS:
                read_value = {RESERVED_BIT_VALUE, state.b3_op};
            BUCK_THREE_SCALING_VOLTAGE_OFS:
                read_value = DATA_W'(state.b3_avs);
            BUCK_THREE_VOLTAGE_LIMIT_OFS:
                read_value = DATA_W'(state.b3_limit);
            BUCK_FOUR_OPERATING_VOLTAGE_OFS:
                read_value = {RESERVED_BIT_VALUE, state.b4_op};
            default:
                read_value = READ_UNMAPPED;
        endcase
        next_state.rdata = read_value;

        // forced-off overrides the enable bit; it reaches the output one
        // cycle late, the same as a write to the enable bit
        next_state.b3_enable = next_state.b3_avs.enable
                               && !buck_three_forced_off;
        // source select high picks the operating code, low the scaling code
        next_state.b3_code = next_state.b3_op.code_source_select
                             ? next_state.b3_op.code
                             : next_state.b3_avs.code;

        // power-on reset and configuration reload load the programmed
        // defaults; reset and reload are the only ways out of a ceiling lock
        if (sys_rst || cfg_reload) begin
            next_state.b2_limit = cfg_buck_two_limit;
            next_state.b3_limit = cfg_buck_three_limit;
            next_state.b3_op.code_source_select = SOURCE_RESET;
            next_state.b3_op.code = cfg_buck_three_op_code;
            next_state.b3_avs.enable = cfg_buck_three_enable;
            next_state.b3_avs.light_load = SOURCE_RESET;
            next_state.b3_avs.code = cfg_buck_three_avs_code;
            next_state.b4_op.code_source_select = SOURCE_RESET;
            next_state.b4_op.code = cfg_buck_four_op_code;
            next_state.rdata = READ_UNMAPPED;
            next_state.b3_enable = 1'b0;
            next_state.b3_code = cfg_buck_three_avs_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers: synchronous reset, so defaults may come from inputs

    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; the range fields tell the converters how to read the codes
    // (base and step per encoding of bvl_range_t)

    assign reg_rdata = state.rdata;
    assign buck_two_range = state.b2_limit.range;
    assign buck_two_ceiling = state.b2_limit.ceiling;
    assign buck_two_locked = b2_lock;
    assign buck_three_range = state.b3_limit.range;
    assign buck_three_code = state.b3_code;
    assign buck_three_enable = state.b3_enable;
    assign buck_three_light_load = state.b3_avs.light_load;
    assign buck_three_locked = b3_lock;
    assign buck_four_op_code = state.b4_op.code;
    assign buck_four_code_source_select = state.b4_op.code_source_select;
endmodule // bvl_regs
`default_nettype wire

//--- sim/bvl_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bvl_regs_sva (
    // clock and reset
    input wire logic                       sys_clk,
    input wire logic                       sys_rst,
    // configuration and register port
    input wire logic                       cfg_reload,
    input wire bvl_pkg::bvl_limit_t        cfg_buck_two_limit,
    input wire logic                       reg_write,
    input wire logic [bvl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [bvl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [bvl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [bvl_pkg::CODE_W-1:0] buck_four_ceiling,
    input wire logic                       buck_three_forced_off,
    // converter controls
    input wire bvl_pkg::bvl_range_t        buck_two_range,
    input wire logic [bvl_pkg::CODE_W-1:0] buck_two_ceiling,
    input wire logic                       buck_two_locked,
    input wire logic                       buck_three_enable,
    input wire logic [bvl_pkg::CODE_W-1:0] buck_four_op_code,
    input wire logic                       buck_four_code_source_select
);
    import bvl_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // reset itself is the cause here, so this one must not be disabled by it
    property p_defaults;
        disable iff (1'b0) (sys_rst || cfg_reload) |=>
            {buck_two_range, buck_two_ceiling} == $past(cfg_buck_two_limit);
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("limit default not loaded");
    property p_lock_flag;
        buck_two_locked == (buck_two_ceiling != 6'h00
                            && buck_two_ceiling != 6'h3f);
    endproperty
    a_lock_flag: assert property (p_lock_flag)
        else $error("lock flag wrong");
    property p_lock_hold;
        buck_two_locked && !cfg_reload |=>
            $stable({buck_two_range, buck_two_ceiling});
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked limit changed");
    property p_unmapped;
        !(reg_addr inside {[8'h09:8'h0d]}) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_reserved;
        reg_addr == 8'h0a || reg_addr == 8'h0d |=> !reg_rdata[7];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit reads one");
    property p_forced;
        buck_three_forced_off |=> !buck_three_enable;
    endproperty
    a_forced: assert property (p_forced)
        else $error("enable while forced off");
    property p_enable_write;
        reg_write && reg_addr == 8'h0b && !cfg_reload
            && !buck_three_forced_off ##1 !buck_three_forced_off
            |-> buck_three_enable == $past(reg_wdata[7]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable bit not applied");
    property p_clamp;
        reg_write && reg_addr == 8'h0d && !cfg_reload |=>
            buck_four_op_code == ($past(reg_wdata[5:0]) >
            $past(buck_four_ceiling) ? $past(buck_four_ceiling)
            : $past(reg_wdata[5:0]));
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("code not clamped");
    property p_source;
        reg_write && reg_addr == 8'h0d && !cfg_reload |=>
            buck_four_code_source_select == $past(reg_wdata[6]);
    endproperty
    a_source: assert property (p_source)
        else $error("source select not stored");
endmodule // bvl_regs_sva
bind bvl_regs bvl_regs_sva u_sva (.sys_clk, .sys_rst, .cfg_reload,
    .cfg_buck_two_limit, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
    .buck_four_ceiling, .buck_three_forced_off, .buck_two_range,
    .buck_two_ceiling, .buck_two_locked, .buck_three_enable,
    .buck_four_op_code, .buck_four_code_source_select);
`default_nettype wire

//--- sim/buck_voltage_limit_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module buck_voltage_limit_regs_test;
    import bvl_pkg::*;
    logic       sys_clk = 1'b0, sys_rst = 1'b1, cfg_reload = 1'b0;
    logic       reg_write = 1'b0, rd_req = 1'b0, pend = 1'b0;
    logic       buck_three_forced_off = 1'b0;
    logic       cfg_en = 1'b1;
    logic [5:0] b4_ceil = 6'h20;
    bvl_limit_t lim2 = 8'h4a, lim3 = 8'h3f;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, exp_q[$];
    logic [5:0] c, b2c, b3c, b4c;
    bvl_range_t b2r, b3r;
    logic       b2l, b3l, b3e, b3ll, b4s;
    int         n_mismatch = 0, num_checks = 0;
    always #10 sys_clk = ~sys_clk;
    bvl_regs uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cfg_reload(cfg_reload), .cfg_buck_two_limit(lim2),
        .cfg_buck_three_limit(lim3), .cfg_buck_three_enable(cfg_en),
        .cfg_buck_three_op_code(6'h03), .cfg_buck_three_avs_code(6'h05),
        .cfg_buck_four_op_code(6'h07), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .buck_four_ceiling(b4_ceil),
        .buck_three_forced_off(buck_three_forced_off),
        .buck_two_range(b2r), .buck_two_ceiling(b2c), .buck_two_locked(b2l),
        .buck_three_range(b3r), .buck_three_code(b3c),
        .buck_three_enable(b3e), .buck_three_light_load(b3ll),
        .buck_three_locked(b3l), .buck_four_op_code(b4c),
        .buck_four_code_source_select(b4s));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // tasks start and end on a falling edge; the write strobe stays up
    // between back-to-back writes, rd and idle drop it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rd_req = 1'b0;
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
    endtask
    // read strobe is left up so reads can run back to back
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_write = 1'b0;
        reg_addr = a;
        rd_req = 1'b1;
        exp_q.push_back(e);
        @(negedge sys_clk);
    endtask
    task automatic idle(input int n);
        reg_write = 1'b0;
        rd_req = 1'b0;
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // read data are registered at the edge that samples the address and
    // stand only until the next edge, so look just after that same edge
    always @(posedge sys_clk) begin
        pend = rd_req;
        #1;
        if (pend === 1'b1) chk(reg_rdata, exp_q.pop_front());
    end
    initial begin
        #100us;
        n_mismatch++;
        stop_test;
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h625f));
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        rd(8'h09, 8'h4a);
        rd(8'h0c, 8'h3f);
        rd(8'h0a, 8'h03);
        rd(8'h0b, 8'h85);
        rd(8'h0d, 8'h07);
        rd(8'h08, 8'h00);
        rd(8'h0e, 8'h00);
        wr(8'h09, 8'h00);
        rd(8'h09, 8'h4a);
        chk(b2l, 1'b1);
        chk({b2r, b2c}, 8'h4a);
        for (int r = 0; r < 4; r++) begin
            c = r[0] ? 6'h3f : 6'h00;
            wr(8'h0c, {r[1:0], c});
            rd(8'h0c, {r[1:0], c});
            chk(b3r, r[1:0]);
        end
        wr(8'h0c, 8'h90);
        wr(8'h0c, 8'h3f);
        rd(8'h0c, 8'h90);
        chk(b3l, 1'b1);
        wr(8'h0a, 8'h7f);
        rd(8'h0a, 8'h50);
        wr(8'h0b, 8'h9f);
        rd(8'h0b, 8'h90);
        repeat (4) begin
            c = 6'($urandom % 17);
            wr(8'h0b, {2'b11, c});
            rd(8'h0b, {2'b11, c});
        end
        chk(b3ll, 1'b1);
        chk(b3c, 6'h10);
        wr(8'h0a, 8'h05);
        rd(8'h0a, 8'h05);
        chk(b3c, c);
        buck_three_forced_off = 1'b1;
        idle(2);
        chk(b3e, 1'b0);
        buck_three_forced_off = 1'b0;
        idle(2);
        chk(b3e, 1'b1);
        wr(8'h0d, 8'h7f);
        rd(8'h0d, 8'h60);
        chk(b4s, 1'b1);
        c = 6'($urandom % 33);
        wr(8'h0d, {2'b00, c});
        rd(8'h0d, {2'b00, c});
        chk(b4c, c);
        b4_ceil = 6'h08;
        wr(8'h0d, 8'h3c);
        rd(8'h0d, 8'h08);
        cfg_en = 1'b0;
        cfg_reload = 1'b1;
        idle(1);
        cfg_reload = 1'b0;
        rd(8'h0c, 8'h3f);
        rd(8'h0b, 8'h05);
        chk(b3ll, 1'b0);
        wr(8'h0c, 8'h55);
        rd(8'h0c, 8'h55);
        // power-on reset in mid-run must also lift the lock
        sys_rst = 1'b1;
        idle(2);
        sys_rst = 1'b0;
        rd(8'h0c, 8'h3f);
        rd(8'h0a, 8'h03);
        chk(b3e, 1'b0);
        idle(2);
        stop_test;
    end
endmodule // buck_voltage_limit_regs_test
`default_nettype wire
